// ### rtl/mad_decoder.sv
// Mode dependent address decoder with registered one-hot region selects.
//
// Summary of operation
// - Mode 6 window: enable picks external, else ROM
// - Mode 6 upper: enable picks external, else reserved
// - Mode 7 window: enable picks reserved, else ROM
// - Expanded modes, RAM disabled: RAM area external
// - Mode 3: I/O from FE40, RAM to FBFF
`timescale 1ns/1ps
`default_nettype none

`include "mad_params.svh"

module mad_decoder (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [`MAD_ADDR_W-1:0] addr,
    input wire logic [`MAD_MODE_W-1:0] mode,
    input wire logic external_area_enable,
    input wire logic ram_enable,
    output logic sel_rom,
    output logic sel_ram,
    output logic sel_io,
    output logic sel_reserved,
    output logic sel_external
);

    // ----------------------------------------------------------------
    // Region predicates
    // ----------------------------------------------------------------
    // Both bounds are inclusive, since the map gives last addresses.
    function automatic logic in_rng(input logic [`MAD_ADDR_W-1:0] a,
                                    input logic [`MAD_ADDR_W-1:0] lo,
                                    input logic [`MAD_ADDR_W-1:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // Normal modes drive only 16 address bits, so the upper byte is
    // ignored rather than trusted to be zero.
    function automatic logic [`MAD_ADDR_W-1:0] nrm_addr(
        input logic [`MAD_ADDR_W-1:0] a
    );
        nrm_addr = {8'h00, a[15:0]};
    endfunction

    function automatic logic nrm_is_io(input logic [`MAD_ADDR_W-1:0] a);
        logic [`MAD_ADDR_W-1:0] na;
        na = nrm_addr(a);
        nrm_is_io = in_rng(na, `MAD_NRM_IO_BASE, `MAD_NRM_IO_END) ||
                    (na >= `MAD_NRM_IO2_BASE);
    endfunction

    function automatic logic nrm_is_ram(input logic [`MAD_ADDR_W-1:0] a);
        nrm_is_ram = in_rng(nrm_addr(a), `MAD_NRM_RAM_BASE,
                            `MAD_NRM_RAM_END);
    endfunction

    function automatic logic nrm_is_rom(input logic [`MAD_ADDR_W-1:0] a);
        nrm_is_rom = nrm_addr(a) <= `MAD_NRM_ROM_END;
    endfunction

    function automatic logic adv_is_io(input logic [`MAD_ADDR_W-1:0] a);
        adv_is_io = in_rng(a, `MAD_ADV_IO_BASE, `MAD_ADV_IO_END) ||
                    (a >= `MAD_ADV_IO2_BASE);
    endfunction

    function automatic logic adv_is_ram(input logic [`MAD_ADDR_W-1:0] a);
        adv_is_ram = in_rng(a, `MAD_ADV_RAM_BASE, `MAD_ADV_RAM_END);
    endfunction

    function automatic logic adv_is_rom(input logic [`MAD_ADDR_W-1:0] a);
        adv_is_rom = a <= `MAD_ADV_ROM_END;
    endfunction

    // Window that the area enable splits between ROM and a neighbour.
    function automatic logic adv_in_win(input logic [`MAD_ADDR_W-1:0] a);
        adv_in_win = in_rng(a, `MAD_ADV_WIN_BASE, `MAD_ADV_WIN_END);
    endfunction

    function automatic logic adv_in_rsv(input logic [`MAD_ADDR_W-1:0] a);
        adv_in_rsv = in_rng(a, `MAD_ADV_RSV_BASE, `MAD_ADV_RSV_END);
    endfunction

    // ----------------------------------------------------------------
    // Per-mode decode
    // ----------------------------------------------------------------
    // Expanded normal modes send every address that no on-chip region
    // claims out to the external bus.
    function automatic logic [`MAD_RGN_W-1:0] dec_nrm_exp(
        input logic [`MAD_ADDR_W-1:0] a,
        input logic rom_on,
        input logic ram_on
    );
        logic [`MAD_RGN_W-1:0] sel;
        sel = `MAD_SEL_EXT;
        if (nrm_is_io(a)) begin
            sel = `MAD_SEL_IO;
        end else if (nrm_is_ram(a) && ram_on) begin
            sel = `MAD_SEL_RAM;
        end else if (nrm_is_rom(a) && rom_on) begin
            sel = `MAD_SEL_ROM;
        end
        dec_nrm_exp = sel;
    endfunction

    // Single-chip normal mode has no external bus, so gaps are reserved
    // and the RAM enable is not consulted.
    function automatic logic [`MAD_RGN_W-1:0] dec_nrm_single(
        input logic [`MAD_ADDR_W-1:0] a
    );
        logic [`MAD_RGN_W-1:0] sel;
        sel = `MAD_SEL_RSV;
        if (nrm_is_io(a)) begin
            sel = `MAD_SEL_IO;
        end else if (nrm_is_ram(a)) begin
            sel = `MAD_SEL_RAM;
        end else if (nrm_is_rom(a)) begin
            sel = `MAD_SEL_ROM;
        end
        dec_nrm_single = sel;
    endfunction

    // Expanded advanced modes; the ROM and its window exist only when
    // the on-chip ROM is enabled.
    function automatic logic [`MAD_RGN_W-1:0] dec_adv_exp(
        input logic [`MAD_ADDR_W-1:0] a,
        input logic rom_on,
        input logic area_on,
        input logic ram_on
    );
        logic [`MAD_RGN_W-1:0] sel;
        sel = `MAD_SEL_EXT;
        if (adv_is_io(a)) begin
            sel = `MAD_SEL_IO;
        end else if (adv_is_ram(a) && ram_on) begin
            sel = `MAD_SEL_RAM;
        end else if (rom_on && adv_is_rom(a)) begin
            sel = `MAD_SEL_ROM;
        end else if (rom_on && adv_in_win(a)) begin
            sel = area_on ? `MAD_SEL_EXT : `MAD_SEL_ROM;
        end else if (rom_on && adv_in_rsv(a)) begin
            sel = area_on ? `MAD_SEL_EXT : `MAD_SEL_RSV;
        end
        dec_adv_exp = sel;
    endfunction

    // Advanced single-chip mode: the window above the ROM becomes
    // reserved when the area enable is set, and the rest of the space
    // has nowhere to go.
    function automatic logic [`MAD_RGN_W-1:0] dec_adv_single(
        input logic [`MAD_ADDR_W-1:0] a,
        input logic area_on
    );
        logic [`MAD_RGN_W-1:0] sel;
        sel = `MAD_SEL_RSV;
        if (adv_is_io(a)) begin
            sel = `MAD_SEL_IO;
        end else if (adv_is_ram(a)) begin
            sel = `MAD_SEL_RAM;
        end else if (adv_is_rom(a)) begin
            sel = `MAD_SEL_ROM;
        end else if (adv_in_win(a)) begin
            sel = area_on ? `MAD_SEL_RSV : `MAD_SEL_ROM;
        end
        dec_adv_single = sel;
    endfunction

    // ----------------------------------------------------------------
    // Region select
    // ----------------------------------------------------------------
    logic [`MAD_RGN_W-1:0] sel_reg;
    logic [`MAD_RGN_W-1:0] sel_next;

    always_comb begin
        sel_next = `MAD_SEL_RSV;
        case (mode)
            mad_pkg::MAD_M1: begin
                sel_next = dec_nrm_exp(addr, 1'b0, ram_enable);
            end
            mad_pkg::MAD_M2: begin
                sel_next = dec_nrm_exp(addr, 1'b1, ram_enable);
            end
            mad_pkg::MAD_M3: begin
                sel_next = dec_nrm_single(addr);
            end
            // Modes 4 and 5 run with the on-chip ROM switched off.
            mad_pkg::MAD_M4, mad_pkg::MAD_M5: begin
                sel_next = dec_adv_exp(addr, 1'b0, external_area_enable,
                                       ram_enable);
            end
            mad_pkg::MAD_M6: begin
                sel_next = dec_adv_exp(addr, 1'b1, external_area_enable,
                                       ram_enable);
            end
            mad_pkg::MAD_M7: begin
                sel_next = dec_adv_single(addr, external_area_enable);
            end
            // Unsupported mode codes answer nothing on chip.
            default: begin
                sel_next = `MAD_SEL_RSV;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Output register
    // ----------------------------------------------------------------
    // Reset value is a single region so one-hot holds from reset on.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sel_reg <= `MAD_SEL_RSV;
        end else begin
            sel_reg <= sel_next;
        end
    end

    assign sel_rom = sel_reg[0];
    assign sel_ram = sel_reg[1];
    assign sel_io = sel_reg[2];
    assign sel_reserved = sel_reg[3];
    assign sel_external = sel_reg[4];

endmodule

`default_nettype wire

// ### rtl/mad_params.svh
// Address map boundaries and region select codes for the mode address decoder.
`ifndef MAD_PARAMS_SVH
`define MAD_PARAMS_SVH

`define MAD_ADDR_W 24
`define MAD_MODE_W 4
`define MAD_RGN_W 5
`define MAD_NRM_ROM_END 24'h00dfff
`define MAD_NRM_RAM_BASE 24'h00ec00
`define MAD_NRM_RAM_END 24'h00fbff
`define MAD_NRM_IO_BASE 24'h00fe40
`define MAD_NRM_IO_END 24'h00ff07
`define MAD_NRM_IO2_BASE 24'h00ff28
`define MAD_ADV_ROM_END 24'h00ffff
`define MAD_ADV_WIN_BASE 24'h010000
`define MAD_ADV_WIN_END 24'h017fff
`define MAD_ADV_RSV_BASE 24'h018000
`define MAD_ADV_RSV_END 24'h01ffff
`define MAD_ADV_RAM_BASE 24'hffec00
`define MAD_ADV_RAM_END 24'hfffbff
`define MAD_ADV_IO_BASE 24'hfffe40
`define MAD_ADV_IO_END 24'hffff07
`define MAD_ADV_IO2_BASE 24'hffff28
`define MAD_SEL_ROM 5'h01
`define MAD_SEL_RAM 5'h02
`define MAD_SEL_IO 5'h04
`define MAD_SEL_RSV 5'h08
`define MAD_SEL_EXT 5'h10

`endif

// ### rtl/mad_pkg.sv
// Types shared by the mode address decoder.
package mad_pkg;
    typedef enum logic [3:0] {
        MAD_M1 = 4'h1, MAD_M2 = 4'h2, MAD_M3 = 4'h3, MAD_M4 = 4'h4,
        MAD_M5 = 4'h5, MAD_M6 = 4'h6, MAD_M7 = 4'h7
    } mad_mode_t;
endpackage

// ### testbench/mad_decoder_sva.sv
// Assertions on the region selects of the mode address decoder.
`timescale 1ns/1ps
`default_nettype none
module mad_decoder_sva (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [23:0] addr,
    input wire logic [3:0] mode,
    input wire logic external_area_enable,
    input wire logic ram_enable,
    input wire logic sel_rom,
    input wire logic sel_ram,
    input wire logic sel_io,
    input wire logic sel_reserved,
    input wire logic sel_external
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire logic lo = addr inside {[24'h010000:24'h017fff]};
    wire logic hi = addr inside {[24'h018000:24'h01ffff]};
    a_low_expanded:
        assert property (mode == 4'h6 && lo |=> $past(external_area_enable)
            ? sel_external : sel_rom) else $error("low window wrong");
    a_high_expanded:
        assert property (mode == 4'h6 && hi |=> $past(external_area_enable)
            ? sel_external : sel_reserved) else $error("high window wrong");
    a_low_single:
        assert property (mode == 4'h7 && lo |=> $past(external_area_enable)
            ? sel_reserved : sel_rom) else $error("single window wrong");
    a_ram_off:
        assert property (!ram_enable && mode inside {[4'h4:4'h6]} &&
            addr inside {[24'hffec00:24'hfffbff]} |=> sel_external)
            else $error("disabled ram not external");
    a_ram_off_normal:
        assert property (!ram_enable && mode inside {4'h1, 4'h2} &&
            addr[15:0] inside {[16'hec00:16'hfbff]} |=> sel_external)
            else $error("disabled normal ram not external");
    a_io_single:
        assert property (mode == 4'h3 && addr[15:0] inside
            {[16'hfe40:16'hff07]} |=> sel_io) else $error("io wrong");
    a_ram_single:
        assert property (mode == 4'h3 && addr[15:0] inside
            {[16'hec00:16'hfbff]} |=> sel_ram) else $error("ram wrong");
    a_one_hot:
        assert property ($onehot({sel_rom, sel_ram, sel_io, sel_reserved,
            sel_external})) else $error("selects not one-hot");
endmodule
`default_nettype wire

// ### testbench/mad_cpu_model.sv
// Bus master model: {mode, area enable, ram enable, address} request.
`timescale 1ns/1ps
`default_nettype none
module mad_cpu_model (
    input wire logic clk_sys,
    input wire logic [29:0] req,
    output var logic [29:0] bus
);
    // Falling edge launch keeps the address settled at the sampling edge.
    initial bus = 30'h0;
    always @(negedge clk_sys) bus <= req;
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench of the mode address decoder.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [29:0] req = 30'h0;
    logic [23:0] s = 24'h000027;
    logic [4:0] prev = 5'h08;
    wire logic [29:0] bus;
    wire logic [4:0] sel;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    logic [23:0] tbl [15] = '{24'h00dfff, 24'h00e000, 24'h00ffff,
        24'h010000, 24'h017fff, 24'h018000, 24'h01ffff, 24'h020000,
        24'hffec00, 24'hfffbff, 24'hfffc00, 24'hfffe40, 24'hffff07,
        24'hffff08, 24'hffff28};
    mad_cpu_model u_cpu (.clk_sys(clk_sys), .req(req), .bus(bus));
    mad_decoder u_dut (.clk_sys(clk_sys), .rstn(rstn), .addr(bus[23:0]),
        .mode(bus[29:26]), .external_area_enable(bus[25]),
        .ram_enable(bus[24]), .sel_rom(sel[0]), .sel_ram(sel[1]),
        .sel_io(sel[2]), .sel_reserved(sel[3]), .sel_external(sel[4]));
    function automatic logic [23:0] lfsr(logic [23:0] v);
        return {v[22:0], v[23] ^ v[22] ^ v[21] ^ v[16]};
    endfunction
    function automatic logic [4:0] want(logic [29:0] q);
        logic [3:0] m = q[29:26];
        logic [23:0] a = m < 4 ? {8'hff, q[15:0]} : q[23:0];
        if (m == 0 || m > 7) return 5'h08;
        if ((a >= 24'hfffe40 && a <= 24'hffff07) || a >= 24'hffff28)
            return 5'h04;
        if (a >= 24'hffec00 && a <= 24'hfffbff && (q[24] || m[1:0] == 3))
            return 5'h02;
        if (m < 4) return m > 1 && a <= 24'hffdfff ? 5'h01 :
            m == 3 ? 5'h08 : 5'h10;
        if (m < 6) return 5'h10;
        if (a <= 24'h00ffff || (a <= 24'h017fff && !q[25])) return 5'h01;
        return m == 6 && (q[25] || a > 24'h01ffff) ? 5'h10 : 5'h08;
    endfunction
    task automatic check(input logic [4:0] got, input logic [4:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial forever #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        for (int m = 0; m < 9; m++) begin
            for (int k = 0; k < 100; k++) begin
                @(posedge clk_sys);
                #1;
                check(sel, prev);
                s = lfsr(s);
                req = {m[3:0], k < 60 ? {k[1:0], tbl[k >> 2]} :
                    {s[7:6], {8{s[20]}}, s[15:0]}};
                prev = want(req);
            end
        end
        @(posedge clk_sys);
        #1;
        check(sel, prev);
        // Mid-run reset: a held window access must fall back to the lone
        // reserved select, then return once reset is released.
        req = {4'h6, 2'b10, 24'h010000};
        @(posedge clk_sys);
        #1;
        check(sel, 5'h10);
        @(negedge clk_sys);
        rstn = 1'b0;
        #1;
        check(sel, 5'h08);
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        @(posedge clk_sys);
        #1;
        check(sel, 5'h10);
        summarize();
    end
endmodule
bind mad_decoder mad_decoder_sva u_sva (.clk_sys(clk_sys), .rstn(rstn),
    .addr(addr), .mode(mode), .external_area_enable(external_area_enable),
    .ram_enable(ram_enable), .sel_rom(sel_rom), .sel_ram(sel_ram),
    .sel_io(sel_io), .sel_reserved(sel_reserved),
    .sel_external(sel_external));
`default_nettype wire
